// [rtl/uvrc_defines.svh]
/*
  constants of the undervoltage reset control block: register offsets,
  codes, reset values and timing counts.
  assumes inclusion by bare name from rtl/ files.
*/
`ifndef UVRC_DEFINES_SVH
`define UVRC_DEFINES_SVH
`define UVRC_OFF_UVSEL      5'h00
`define UVRC_OFF_CAUSE      5'h04
`define UVRC_OFF_GUARD      5'h08
`define UVRC_OFF_WDCTL      5'h0C
`define UVRC_OFF_PORT       5'h10
`define UVRC_OFF_IMASK      5'h14
`define UVRC_OFF_STAT       5'h18
`define UVRC_TH_1V7         8'h66
`define UVRC_TH_1V9         8'h55
`define UVRC_TH_2V55        8'h33
`define UVRC_TH_3V15        8'h99
`define UVRC_TH_3V8         8'hAA
`define UVRC_TH_OFF         8'hF0
`define UVRC_GUARD_A        8'h55
`define UVRC_GUARD_B        8'hAA
`define UVRC_GUARD_POR      8'h55
`define UVRC_WDCTL_POR      8'h52
`define UVRC_UVSEL_POR      8'h66
`define UVRC_PORT_POR       8'hFF
`define UVRC_PCL_POR        8'h00
`define UVRC_BIT_GUARDF     3
`define UVRC_BIT_UVF        2
`define UVRC_BIT_THF        1
`define UVRC_BIT_WDF        0
`define UVRC_FILT_CYC       16'h0008
`define UVRC_FAULT_CYC      16'h0010
`endif

// [rtl/uvrc_pkg.sv]
/*
  types of the undervoltage reset control block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package uvrc_pkg;
  typedef enum logic [2:0] {
    UVRC_TH_NONE,
    UVRC_TH_SEL_1V7,
    UVRC_TH_SEL_1V9,
    UVRC_TH_SEL_2V55,
    UVRC_TH_SEL_3V15,
    UVRC_TH_SEL_3V8
  } uvrc_level_t;
endpackage : uvrc_pkg

// [rtl/uvrc_delay.sv]
/*
  delay counter on a low-speed tick: done after tick count passes limit
  while start holds; clears as soon as start drops.
  assumes tick_i is a one-cycle pulse on clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module uvrc_delay (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic        tick_i,
  input  wire logic [15:0] limit_i,
  output logic             done_o
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (!start_i) begin
      cnt_next = 16'h0000;
    end else if (tick_i && cnt_reg <= limit_i) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // strictly longer than the limit
  assign done_o = start_i && (cnt_reg > limit_i);
endmodule : uvrc_delay
`default_nettype wire

// [rtl/uvrc_top.sv]
/*
  undervoltage reset control: threshold select decode, guard code check,
  reset cause flags, watchdog expiry and power-down flags, and the
  per-reset-type values of port, program counter, guard and watchdog
  control registers; AXI4-Lite register slave with interrupt.
  assumes resetn_i is the power-on reset; pins pass two flip-flops.
*/
// The register offsets and the AXI4-Lite register port were decided locally.
// Summary of operation
// - five select codes pick 1.7, 1.9, 2.55, 3.15 or 3.8 V thresholds.
// - select code 0xF0 disables undervoltage reset and is not a fault.
// - undervoltage reset after filter time below threshold; select kept.
// - any other select code resets after fault delay, restores 0x66.
// - undervoltage reset sets cause bit 2; software clears by writing 0.
// - undefined select code sets cause bit 1; software clears it.
// - run-mode watchdog expiry acts as pin reset plus expiry flag.
// - sleep watchdog expiry clears only pc and sp, sets expiry flag.
// - expiry and power-down flags follow the reset type table.
// - power-on zeros pc, masks interrupts, clears timers, ports input.
// - most resets load ports 0xFF and pc low 0x00; sleep keeps ports.
// - guard gets 0x55 and watchdog control 0x52 except sleep expiry.
// - expiry and power-down flags live in the processor status word.
// - bad guard code resets after fault delay and sets cause bit 3.
// - undervoltage detection is off during idle or sleep.
`timescale 1ns/10ps
`default_nettype none
`include "uvrc_defines.svh"
module uvrc_top (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        slow_tick_i,
  input  wire logic        below_1v7_i,
  input  wire logic        below_1v9_i,
  input  wire logic        below_2v55_i,
  input  wire logic        below_3v15_i,
  input  wire logic        below_3v8_i,
  input  wire logic        ext_clear_n_i,
  input  wire logic        wdog_expire_i,
  input  wire logic        sleep_idle_i,
  input  wire logic        enter_sleep_i,
  input  wire logic        wdog_clear_i,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [4:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [4:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             mcu_reset_o,
  output logic             core_clear_o,
  output logic             periph_clear_o,
  output logic             uv_enabled_o,
  output logic [2:0]       uv_level_o,
  output logic             watchdog_expiry_flag_o,
  output logic             powerdown_flag_o,
  output logic [7:0]       port_data_o,
  output logic [7:0]       port_dir_o,
  output logic [7:0]       program_counter_low_byte_o,
  output logic             irq_o
);
  // pin and monitor inputs cross in two flops
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  logic [7:0] pins;
  assign pins = {sleep_idle_i, wdog_expire_i, ext_clear_n_i, below_3v8_i,
                 below_3v15_i, below_2v55_i, below_1v9_i, below_1v7_i};
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s1_reg <= 8'h20;
      s2_reg <= 8'h20;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
    end
  end
  logic sleepy;
  logic ext_low;
  logic wd_exp;
  assign sleepy  = s2_reg[7];
  assign wd_exp  = s2_reg[6];
  assign ext_low = !s2_reg[5];

  logic [7:0] undervoltage_select_register_reg;
  logic [7:0] undervoltage_select_register_next;
  logic [7:0] reset_guard_register_reg, reset_guard_register_next;
  logic [7:0] watchdog_control_register_reg, watchdog_control_register_next;
  logic [3:0] reset_cause_register_reg, reset_cause_register_next;
  logic [3:0] imask_reg, imask_next;
  logic [7:0] port_reg, port_next;
  logic [7:0] dir_reg, dir_next;
  logic       to_reg, to_next;
  logic       pd_reg, pd_next;
  logic       rst_reg, rst_next;
  logic       wdx_reg, wdx_next, part_reg, part_next;

  // threshold decode
  uvrc_pkg::uvrc_level_t level;
  logic th_valid;
  logic uv_below;
  always_comb begin
    level    = uvrc_pkg::UVRC_TH_NONE;
    th_valid = 1'b1;
    uv_below = 1'b0;
    unique case (undervoltage_select_register_reg)
      `UVRC_TH_1V7: begin level = uvrc_pkg::UVRC_TH_SEL_1V7; uv_below = s2_reg[0]; end
      `UVRC_TH_1V9: begin level = uvrc_pkg::UVRC_TH_SEL_1V9; uv_below = s2_reg[1]; end
      `UVRC_TH_2V55: begin level = uvrc_pkg::UVRC_TH_SEL_2V55; uv_below = s2_reg[2]; end
      `UVRC_TH_3V15: begin level = uvrc_pkg::UVRC_TH_SEL_3V15; uv_below = s2_reg[3]; end
      `UVRC_TH_3V8: begin level = uvrc_pkg::UVRC_TH_SEL_3V8; uv_below = s2_reg[4]; end
      `UVRC_TH_OFF: th_valid = 1'b1;
      default: th_valid = 1'b0;
    endcase
  end
  logic guard_ok;
  assign guard_ok = (reset_guard_register_reg == `UVRC_GUARD_A) ||
                    (reset_guard_register_reg == `UVRC_GUARD_B);
  assign uv_enabled_o = (level != uvrc_pkg::UVRC_TH_NONE) && !sleepy;
  assign uv_level_o   = level;

  // delays counted on the slow tick
  logic uv_done, fault_done;
  uvrc_delay u_filt (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (uv_enabled_o && uv_below && !rst_reg),
    .tick_i   (slow_tick_i),
    .limit_i  (`UVRC_FILT_CYC),
    .done_o   (uv_done)
  );
  uvrc_delay u_fault (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  ((!th_valid || !guard_ok) && !rst_reg),
    .tick_i   (slow_tick_i),
    .limit_i  (`UVRC_FAULT_CYC),
    .done_o   (fault_done)
  );

  // reset events
  logic ev_uv, ev_th, ev_gd, ev_ext, ev_wrun, ev_wslp, ev_full;
  assign ev_uv   = uv_done;
  assign ev_th   = fault_done && !th_valid;
  assign ev_gd   = fault_done && !guard_ok;
  assign ev_ext  = ext_low;
  assign ev_wrun = wd_exp && !wdx_reg && !sleepy;
  assign ev_wslp = wd_exp && !wdx_reg && sleepy;
  // any full reset overrides a sleep expiry's partial one
  assign ev_full = ev_uv | ev_th | ev_gd | ev_ext | ev_wrun;

  // AXI4-Lite slave: one write and one read at a time
  logic aw_h_reg, aw_h_next, w_h_reg, w_h_next, b_reg, b_next;
  logic [4:0] wa_reg, wa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0]  ws_reg, ws_next;
  logic r_reg, r_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0]  rr_reg, rr_next, br_reg, br_next;
  logic do_wr;
  assign awready = !aw_h_reg && !b_reg;
  assign wready  = !w_h_reg && !b_reg;
  assign arready = !r_reg;
  assign bvalid  = b_reg;
  assign bresp   = br_reg;
  assign rvalid  = r_reg;
  assign rdata   = rd_reg;
  assign rresp   = rr_reg;
  assign do_wr   = aw_h_reg && w_h_reg && !b_reg;
  logic wl;
  assign wl = ws_reg[0];

  always_comb begin
    aw_h_next = aw_h_reg;
    w_h_next  = w_h_reg;
    wa_next   = wa_reg;
    wd_next   = wd_reg;
    ws_next   = ws_reg;
    b_next    = b_reg;
    br_next   = br_reg;
    r_next    = r_reg;
    rd_next   = rd_reg;
    rr_next   = rr_reg;
    if (awvalid && awready) begin
      aw_h_next = 1'b1;
      wa_next   = awaddr;
    end
    if (wvalid && wready) begin
      w_h_next = 1'b1;
      wd_next  = wdata;
      ws_next  = wstrb;
    end
    if (do_wr) begin
      aw_h_next = 1'b0;
      w_h_next  = 1'b0;
      b_next    = 1'b1;
      br_next   = 2'b00;
      if (wa_reg > `UVRC_OFF_IMASK || wa_reg[1:0] != 2'b00) begin
        br_next = 2'b10;
      end
    end else if (b_reg && bready) begin
      b_next = 1'b0;
    end
    if (arvalid && arready) begin
      r_next  = 1'b1;
      rr_next = 2'b00;
      unique case (araddr)
        `UVRC_OFF_UVSEL: rd_next = {24'h0000_00, undervoltage_select_register_reg};
        `UVRC_OFF_CAUSE: rd_next = {28'h000_0000, reset_cause_register_reg};
        `UVRC_OFF_GUARD: rd_next = {24'h0000_00, reset_guard_register_reg};
        `UVRC_OFF_WDCTL: rd_next = {24'h0000_00, watchdog_control_register_reg};
        `UVRC_OFF_PORT:  rd_next = {16'h0000, dir_reg, port_reg};
        `UVRC_OFF_IMASK: rd_next = {28'h000_0000, imask_reg};
        `UVRC_OFF_STAT:  rd_next = {30'h0000_0000, pd_reg, to_reg};
        default: begin
          rd_next = 32'h0000_0000;
          rr_next = 2'b10;
        end
      endcase
    end else if (r_reg && rready) begin
      r_next = 1'b0;
    end
  end

  // reset-type register behaviour
  logic wr_sel, wr_cause, wr_guard, wr_wdc, wr_port, wr_mask;
  assign wr_sel   = do_wr && wl && wa_reg == `UVRC_OFF_UVSEL;
  assign wr_cause = do_wr && wl && wa_reg == `UVRC_OFF_CAUSE;
  assign wr_guard = do_wr && wl && wa_reg == `UVRC_OFF_GUARD;
  assign wr_wdc   = do_wr && wl && wa_reg == `UVRC_OFF_WDCTL;
  assign wr_port  = do_wr && wa_reg == `UVRC_OFF_PORT;
  assign wr_mask  = do_wr && wl && wa_reg == `UVRC_OFF_IMASK;

  always_comb begin
    undervoltage_select_register_next = undervoltage_select_register_reg;
    reset_guard_register_next      = reset_guard_register_reg;
    watchdog_control_register_next = watchdog_control_register_reg;
    reset_cause_register_next      = reset_cause_register_reg;
    imask_next = imask_reg;
    port_next  = port_reg;
    dir_next   = dir_reg;
    to_next    = to_reg;
    pd_next    = pd_reg;
    rst_next   = ev_full || ev_wslp;
    part_next  = ev_wslp && !ev_full;
    wdx_next   = wd_exp;
    if (wr_sel) undervoltage_select_register_next = wd_reg[7:0];
    if (wr_guard) reset_guard_register_next = wd_reg[7:0];
    if (wr_wdc) watchdog_control_register_next = wd_reg[7:0];
    if (wr_mask) imask_next = wd_reg[3:0];
    if (wr_port && ws_reg[0]) port_next = wd_reg[7:0];
    if (wr_port && ws_reg[1]) dir_next = wd_reg[15:8];
    // software may only clear; zero written clears the bit
    if (wr_cause) begin
      reset_cause_register_next = reset_cause_register_reg & wd_reg[3:0];
    end
    if (enter_sleep_i) pd_next = 1'b1;
    if (wdog_clear_i) begin
      to_next = 1'b0;
      pd_next = 1'b0;
    end
    // set wins over software clear
    if (ev_uv) reset_cause_register_next[`UVRC_BIT_UVF] = 1'b1;
    if (!th_valid) reset_cause_register_next[`UVRC_BIT_THF] = 1'b1;
    if (ev_gd) reset_cause_register_next[`UVRC_BIT_GUARDF] = 1'b1;
    if (ev_th) undervoltage_select_register_next = `UVRC_UVSEL_POR;
    if (ev_wrun || ev_wslp) to_next = 1'b1;
    if (ev_wslp && !ev_full) pd_next = 1'b1;
    if (ev_full) begin
      port_next = `UVRC_PORT_POR;
      dir_next  = `UVRC_PORT_POR;
      reset_guard_register_next      = `UVRC_GUARD_POR;
      watchdog_control_register_next = `UVRC_WDCTL_POR;
      // pin reset restores the select; undervoltage keeps it
      if (ev_ext || ev_wrun || ev_gd) begin
        undervoltage_select_register_next = `UVRC_UVSEL_POR;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      undervoltage_select_register_reg <= `UVRC_UVSEL_POR;
      reset_guard_register_reg      <= `UVRC_GUARD_POR;
      watchdog_control_register_reg <= `UVRC_WDCTL_POR;
      reset_cause_register_reg <= 4'h0;
      imask_reg <= 4'h0;
      port_reg  <= `UVRC_PORT_POR;
      dir_reg   <= `UVRC_PORT_POR;
      to_reg    <= 1'b0;
      pd_reg    <= 1'b0;
      rst_reg   <= 1'b1;
      wdx_reg   <= 1'b0;
      part_reg  <= 1'b0;
      aw_h_reg  <= 1'b0;
      w_h_reg   <= 1'b0;
      wa_reg    <= 5'h00;
      wd_reg    <= 32'h0000_0000;
      ws_reg    <= 4'h0;
      b_reg     <= 1'b0;
      br_reg    <= 2'b00;
      r_reg     <= 1'b0;
      rd_reg    <= 32'h0000_0000;
      rr_reg    <= 2'b00;
    end else begin
      undervoltage_select_register_reg <= undervoltage_select_register_next;
      reset_guard_register_reg      <= reset_guard_register_next;
      watchdog_control_register_reg <= watchdog_control_register_next;
      reset_cause_register_reg <= reset_cause_register_next;
      imask_reg <= imask_next;
      port_reg  <= port_next;
      dir_reg   <= dir_next;
      to_reg    <= to_next;
      pd_reg    <= pd_next;
      rst_reg   <= rst_next;
      wdx_reg   <= wdx_next;
      part_reg  <= part_next;
      aw_h_reg  <= aw_h_next;
      w_h_reg   <= w_h_next;
      wa_reg    <= wa_next;
      wd_reg    <= wd_next;
      ws_reg    <= ws_next;
      b_reg     <= b_next;
      br_reg    <= br_next;
      r_reg     <= r_next;
      rd_reg    <= rd_next;
      rr_reg    <= rr_next;
    end
  end

  // reset outputs: core_clear is pc and sp, periph_clear the rest
  assign mcu_reset_o    = rst_reg;
  assign core_clear_o   = rst_reg;
  assign periph_clear_o = rst_reg && !part_reg;
  assign watchdog_expiry_flag_o = to_reg;
  assign powerdown_flag_o       = pd_reg;
  assign port_data_o            = port_reg;
  assign port_dir_o             = dir_reg;
  assign program_counter_low_byte_o = `UVRC_PCL_POR;
  assign irq_o = |(reset_cause_register_reg & imask_reg);
endmodule : uvrc_top
`default_nettype wire

// [verification/uvrc_top_asserts.sv]
/* port assertions of uvrc_top, bound to it below.
   assumes pins change just after clock edges. */
`timescale 1ns/10ps
`default_nettype none
module uvrc_top_asserts (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       ext_clear_n_i,
  input wire logic       wdog_expire_i,
  input wire logic       sleep_idle_i,
  input wire logic       mcu_reset_o,
  input wire logic       core_clear_o,
  input wire logic       periph_clear_o,
  input wire logic       uv_enabled_o,
  input wire logic [2:0] uv_level_o,
  input wire logic       watchdog_expiry_flag_o,
  input wire logic       powerdown_flag_o,
  input wire logic [7:0] port_data_o,
  input wire logic [7:0] port_dir_o,
  input wire logic [7:0] program_counter_low_byte_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_pcl_zero: assert property (program_counter_low_byte_o == 8'h00)
    else $error("pc low byte not zero");
  chk_core_clear: assert property (core_clear_o == mcu_reset_o)
    else $error("core clear differs from reset");
  chk_off_level: assert property (uv_level_o == 3'd0 |-> !uv_enabled_o)
    else $error("detection on without level");
  chk_sleep_off: assert property (sleep_idle_i [*4] |-> !uv_enabled_o)
    else $error("detection on in sleep");
  chk_pin_reset: assert property (!ext_clear_n_i [*5] |-> mcu_reset_o)
    else $error("pin low without reset");
  chk_ports_init: assert property (mcu_reset_o && periph_clear_o |=>
    port_data_o == 8'hff && port_dir_o == 8'hff)
    else $error("ports not loaded");
  chk_ports_kept: assert property (mcu_reset_o && !periph_clear_o |=>
    $stable(port_data_o) && $stable(port_dir_o))
    else $error("ports changed by sleep reset");
  chk_wdog_flag: assert property ($rose(wdog_expire_i) |->
    ##[1:8] watchdog_expiry_flag_o)
    else $error("expiry flag not set");
  chk_sleep_pd: assert property (sleep_idle_i [*4] ##0 $rose(wdog_expire_i)
    |-> ##[1:8] (powerdown_flag_o && watchdog_expiry_flag_o))
    else $error("sleep expiry flags wrong");
  cov_sleep_rst: cover property (mcu_reset_o && !periph_clear_o);
  cov_pin_rst: cover property (!ext_clear_n_i && mcu_reset_o);
  cov_top_lvl: cover property (uv_enabled_o && uv_level_o == 3'd5);
endmodule : uvrc_top_asserts
bind uvrc_top uvrc_top_asserts i_chk (
  .clk_i, .resetn_i, .ext_clear_n_i, .wdog_expire_i, .sleep_idle_i,
  .mcu_reset_o, .core_clear_o, .periph_clear_o, .uv_enabled_o,
  .uv_level_o, .watchdog_expiry_flag_o, .powerdown_flag_o,
  .port_data_o, .port_dir_o, .program_counter_low_byte_o
);
`default_nettype wire

// [verification/uvrc_core_model.sv]
/* core side model: free slow time base, sleep entry and wake-up.
   assumes go_sleep_i is a level from the bench. */
`timescale 1ns/10ps
`default_nettype none
module uvrc_core_model (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic go_sleep_i,
  input  wire logic core_clear_i,
  output logic      slow_tick_o,
  output logic      sleep_idle_o,
  output logic      enter_sleep_o
);
  logic [1:0] div_reg, div_next;
  logic       go_reg, slp_reg, slp_next;
  always_comb begin
    div_next = div_reg + 2'd1;
    slp_next = slp_reg || (go_sleep_i && !go_reg);
    // a reset of the core ends sleep, as a wake-up would
    if (core_clear_i || !go_sleep_i)
      slp_next = 1'b0;
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      div_reg <= 2'd0;
      go_reg  <= 1'b0;
      slp_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      go_reg  <= go_sleep_i;
      slp_reg <= slp_next;
    end
  end
  assign slow_tick_o   = div_reg == 2'd3;
  assign sleep_idle_o  = slp_reg;
  assign enter_sleep_o = go_sleep_i && !go_reg;
endmodule : uvrc_core_model
`default_nettype wire

// [verification/test_undervoltage_reset_control.sv]
/* self-checking bench of uvrc_top over the register bus.
   assumes uvrc_core_model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_undervoltage_reset_control;
  logic        clk_i = 1'b0, resetn_i = 1'b0, go = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, wdog_clear_i = 1'b0;
  logic        ext_clear_n_i = 1'b1, wdog_expire_i = 1'b0;
  logic [4:0]  below = 5'h0, awaddr = 5'h0, araddr = 5'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, irq_o;
  logic        slow_tick_i, sleep_idle_i, enter_sleep_i, mcu_reset_o;
  logic        core_clear_o, uv_enabled_o, mprev = 1'b0;
  logic [1:0]  bresp, rresp;
  logic [2:0]  uv_level_o;
  logic [7:0]  code, codes [5] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa};
  logic [15:0] pv;
  logic [33:0] q [$];
  int          mismatches = 0, n_compared = 0, cyc = 0, n_rst = 0, m;
  integer      seed = 32'hd4b1;
  uvrc_core_model i_core (.clk_i, .resetn_i, .go_sleep_i(go),
    .core_clear_i(core_clear_o), .slow_tick_o(slow_tick_i),
    .sleep_idle_o(sleep_idle_i), .enter_sleep_o(enter_sleep_i));
  uvrc_top i_dut (.clk_i, .resetn_i, .slow_tick_i, .below_1v7_i(below[0]),
    .below_1v9_i(below[1]), .below_2v55_i(below[2]),
    .below_3v15_i(below[3]), .below_3v8_i(below[4]), .ext_clear_n_i,
    .wdog_expire_i, .sleep_idle_i, .enter_sleep_i, .wdog_clear_i,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .mcu_reset_o, .core_clear_o, .periph_clear_o(),
    .uv_enabled_o, .uv_level_o, .watchdog_expiry_flag_o(),
    .powerdown_flag_o(), .port_data_o(), .port_dir_o(),
    .program_counter_low_byte_o(), .irq_o);
  always #50 clk_i = ~clk_i;
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cy
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic pa, pw, pb;
    @(posedge clk_i);
    {pa, pw, pb} = 3'b111;
    awaddr  <= a;
    wdata   <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (pb) begin
      @(posedge clk_i);
      if (pb && bvalid)
        check({32'h0, bresp}, 34'h0);
      pb = pb && !bvalid;
      pa = pa && !awready;
      pw = pw && !wready;
      {awvalid, wvalid, bready} <= {pa, pw, pb};
    end
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'b00);
    @(posedge clk_i);
    q.push_back({r, d});
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge clk_i);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd
  // expects exactly one reset event since the count n0
  task automatic wait_rst(input int n0);
    for (int k = 0; k < 300 && n_rst == n0; k++)
      @(posedge clk_i);
    check(34'(n_rst - n0), 34'h1);
    while (mcu_reset_o)
      @(posedge clk_i);
    cy(3);
  endtask : wait_rst
  always @(posedge clk_i) begin
    if (rvalid && rready)
      check({rresp, rdata}, q.size() > 0 ? q.pop_front() : 34'bx);
    mprev <= mcu_reset_o;
    if (resetn_i && mcu_reset_o && !mprev)
      n_rst <= n_rst + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    cy(20);
    resetn_i <= 1'b1;
    rd(5'h00, 32'h66);
    rd(5'h08, 32'h55);
    rd(5'h0c, 32'h52);
    rd(5'h10, 32'h0000_ffff);
    rd(5'h18, 32'h0);
    rd(5'h14, 32'h0);
    rd(5'h1c, 32'h0, 2'b10);
    wr(5'h04, 32'h0);
    m = n_rst;
    below <= 5'h01;
    cy(20);
    below <= 5'h00;
    cy(10);
    check(34'(n_rst - m), 34'h0);
    for (int i = 0; i < 5; i++) begin
      wr(5'h00, {24'h0, codes[i]});
      cy(1);
      check({30'h0, uv_enabled_o, uv_level_o}, 34'(i + 9));
      m = n_rst;
      below <= 5'(1 << i);
      wait_rst(m);
      below <= 5'h00;
      rd(5'h00, {24'h0, codes[i]});
      rd(5'h04, 32'h4);
      wr(5'h04, 32'h0);
    end
    wr(5'h00, 32'hf0);
    cy(1);
    check({30'h0, uv_enabled_o, uv_level_o}, 34'h0);
    m = n_rst;
    below <= 5'h1f;
    cy(60);
    below <= 5'h00;
    rd(5'h04, 32'h0);
    check(34'(n_rst - m), 34'h0);
    code = 8'($random(seed));
    while (code inside {codes, 8'hf0})
      code = 8'($random(seed));
    m = n_rst;
    wr(5'h00, {24'h0, code});
    wait_rst(m);
    rd(5'h00, 32'h66);
    rd(5'h04, 32'h2);
    wr(5'h14, 32'h0);
    cy(1);
    check({33'h0, irq_o}, 34'h0);
    wr(5'h14, 32'hf);
    cy(1);
    check({33'h0, irq_o}, 34'h1);
    wr(5'h04, 32'h0);
    cy(1);
    check({33'h0, irq_o}, 34'h0);
    rd(5'h04, 32'h0);
    m = n_rst;
    wr(5'h08, 32'h3c);
    wait_rst(m);
    rd(5'h04, 32'h8);
    rd(5'h08, 32'h55);
    pv = 16'($random(seed)) & 16'h7fff;
    wr(5'h10, {16'h0, pv});
    wr(5'h08, 32'haa);
    wr(5'h0c, 32'h11);
    go <= 1'b1;
    cy(6);
    m = n_rst;
    below <= 5'h1f;
    cy(60);
    below <= 5'h00;
    check(34'(n_rst - m), 34'h0);
    wdog_expire_i <= 1'b1;
    wait_rst(m);
    {wdog_expire_i, go} <= 2'b00;
    rd(5'h10, {16'h0, pv});
    rd(5'h08, 32'haa);
    rd(5'h0c, 32'h11);
    rd(5'h18, 32'h3);
    wdog_clear_i <= 1'b1;
    cy(1);
    wdog_clear_i <= 1'b0;
    rd(5'h18, 32'h0);
    wr(5'h10, {16'h0, pv});
    m = n_rst;
    wdog_expire_i <= 1'b1;
    wait_rst(m);
    wdog_expire_i <= 1'b0;
    rd(5'h10, 32'h0000_ffff);
    rd(5'h18, 32'h1);
    wr(5'h10, {16'h0, pv});
    wr(5'h0c, 32'h11);
    m = n_rst;
    ext_clear_n_i <= 1'b0;
    cy(8);
    ext_clear_n_i <= 1'b1;
    wait_rst(m);
    rd(5'h10, 32'h0000_ffff);
    rd(5'h0c, 32'h52);
    rd(5'h18, 32'h1);
    cy(2);
    end_of_test();
  end
endmodule : test_undervoltage_reset_control
`default_nettype wire
